// ==== sim/scsi_result_reporter_tb.sv ====
// Bench: drives command events, reads results over AXI4-Lite, compares with a queue.
// Assumes the target model stands in for the bus device.
`timescale 1ns/1ps
`default_nettype none
module scsi_result_reporter_tb import scsi_result_pkg::*;;
  logic clk_sys;
  logic srst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmdKind = 2'h0, selPhase = 2'h0, lag = 2'h0;
  logic cmdStart = 1'b0, cmdSetAtn = 1'b0, paddingOn = 1'b0, rstCond = 1'b0;
  logic busFreeSeen = 1'b0, prevWasXfer = 1'b0, lastAckNeg = 1'b1, go = 1'b0;
  logic [7:0] reselCode = 8'h00, reselStep = 8'h00;
  logic scsiRst, arbLost, reselected, reselOpDone, pauseAcc, selDone, selTimeout;
  logic atnAckDone, busFreeXfer, phaseChange, exitDone, regParErr, busy;
  logic dmaParErr, mpuParErr, scsiParErr, offsetOvr, reqTooFast, xferDone;
  logic atnReq, retryReq, resultPending;
  logic [4:0] errSel = 5'h00, errPulse;
  logic [11:0] pv = 12'h000;
  logic [31:0] rnd = 32'h2bdc2d2e;
  logic [15:0] exq[$];
  int num_errors = 0, cmp_count = 0, retries = 0;
  assign {regParErr, exitDone, phaseChange, busFreeXfer, atnAckDone, selTimeout, selDone,
    pauseAcc, reselOpDone, reselected, arbLost, scsiRst} = pv;
  assign {reqTooFast, offsetOvr, scsiParErr, mpuParErr, dmaParErr} = errPulse;
  scsi_result_reporter #(.DEPTH(4)) scsi_result_reporter_inst (.*);
  scsi_target_model scsi_target_model_inst (.clk_sys(clk_sys), .srst(srst), .go(go),
    .errSel(errSel), .lag(lag), .errPulse(errPulse), .xferDone(xferDone), .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (retryReq === 1'b1) retries <= retries + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Combined codes outrank single ones
  function automatic logic [7:0] xcode(input logic [4:0] e);
    if (e[0] && e[2]) return 8'h25;
    if (e[1] && e[2]) return 8'h26;
    if (e[3] && e[4]) return 8'h2b;
    if (e[0]) return 8'h21;
    if (e[1]) return 8'h22;
    if (e[2]) return 8'h24;
    if (e[3]) return 8'h29;
    return 8'h2a;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    // An edge between reads, so rready is never set twice in one step
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ctl(input logic a, input logic [3:0] n);
    logic [1:0] r;
    axw(ADDR_CTRL, {24'h0, n, 3'h0, a}, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  task automatic cmd(input logic [1:0] k);
    @(posedge clk_sys);
    cmdKind <= k;
    cmdStart <= 1'b1;
    @(posedge clk_sys);
    cmdStart <= 1'b0;
  endtask
  task automatic ev(input int k);
    @(posedge clk_sys);
    pv[k] <= 1'b1;
    @(posedge clk_sys);
    pv <= 12'h000;
  endtask
  // Each queued result must come out whole, code and step in one word
  task automatic drain();
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge clk_sys);
    chk("pending", {31'h0, exq.size() != 0}, {31'h0, resultPending});
    while (exq.size() > 0) begin
      axr(ADDR_RESULT, d, r);
      chk("result", {16'h8000, exq.pop_front()}, d);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] xt[5] = '{16'h0100, 16'h0101, 16'h3101, 16'h3201, 16'h6701};
    int xe[5] = '{0, 0, 8, 9, 4};
    logic [4:0] et[8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h08, 5'h10, 5'h18};
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      selPhase <= (p == 3) ? SP_SEL : p[1:0];
      cmd(CMD_SEL);
      ev(p == 3 ? 5 : 0);
      exq.push_back(p == 3 ? 16'h6003 : {8'h01, 6'h0, p[1:0]});
      drain();
    end
    selPhase <= SP_ARB;
    cmd(CMD_SEL);
    ev(4);
    exq.push_back(16'h6701);
    drain();
    rnd = lfsr(rnd);
    reselCode <= rnd[7:0];
    reselStep <= rnd[15:8];
    cmd(CMD_SEL);
    ev(1);
    ev(2);
    ev(3);
    exq.push_back(16'h6400);
    exq.push_back({rnd[7:0], rnd[15:8]});
    drain();
    ev(3);
    cmd(CMD_SEL);
    exq.push_back({rnd[7:0], rnd[15:8]});
    exq.push_back(16'h6400);
    drain();
    ctl(1'b0, 4'h2);
    cmd(CMD_SEL);
    repeat (3) ev(6);
    repeat (2) @(posedge clk_sys);
    chk("retries", 32'd2, retries);
    exq.push_back(16'h8202);
    drain();
    $display("test select done");
    for (int i = 0; i < 6; i++) begin
      logic a;
      a = (i == 3 || i == 5);
      ctl(a, 4'h0);
      rstCond <= (i == 0);
      busFreeSeen <= (i > 0 && i < 4);
      prevWasXfer <= (i != 2);
      cmdSetAtn <= (i >= 4);
      cmd(CMD_ATNACK);
      if (i >= 4) ev(7);
      if (i == 0) exq.push_back(16'h0100);
      else if (i < 4) exq.push_back((i != 2 && !a) ? 16'h3100 : 16'h7000);
      else exq.push_back(a ? 16'h6009 : 16'h6001);
      drain();
    end
    busFreeSeen <= 1'b0;
    $display("test atnack done");
    for (int k = 0; k < 5; k++) begin
      rstCond <= (k == 0);
      cmd(CMD_XFER);
      if (k > 0) begin
        ev(xe[k]);
        repeat (2) @(posedge clk_sys);
        chk("pending", 32'h0, {31'h0, resultPending});
        ev(10);
      end
      exq.push_back(xt[k]);
      drain();
    end
    rstCond <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ctl(i[0], 4'h0);
      paddingOn <= (i == 7);
      lastAckNeg <= (i != 3);
      cmd(CMD_XFER);
      errSel <= et[i];
      lag <= rnd[1:0];
      go <= 1'b1;
      pv[11] <= (i == 2);
      @(posedge clk_sys);
      go <= 1'b0;
      pv[11] <= 1'b0;
      @(posedge clk_sys iff (|errPulse));
      #1;
      chk("atn", 32'h1, {31'h0, atnReq});
      @(posedge clk_sys iff xferDone);
      exq.push_back({xcode(et[i]), (i[0] && i != 3 && i != 7) ? 8'h09 : 8'h01});
      if (i == 2) exq.push_back(16'h2200);
      drain();
    end
    $display("test transfer done");
    axr(4'hc, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    axw(4'hc, 32'h0, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    // Lane 0 masked: automatic mode from the last transfer test must survive
    s_axi_wstrb <= 4'he;
    axw(ADDR_CTRL, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    axr(ADDR_CTRL, d, r);
    chk("ctrl", 32'h1, d);
    axr(ADDR_RESULT, d, r);
    chk("empty", 32'h0, d);
    $display("test registers done");
    end_sim();
  end
endmodule
`default_nettype wire

// ==== sim/scsi_target_model.sv ====
// Far-side target: after a request it raises the chosen error pulses, then ends the transfer.
// Assumes go is a one-cycle pulse while the model is idle.
`timescale 1ns/1ps
`default_nettype none
module scsi_target_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic go,
  input wire logic [4:0] errSel,
  input wire logic [1:0] lag,
  output logic [4:0] errPulse,
  output logic xferDone,
  output logic busy
);
  logic [2:0] cnt;
  // Lag stretches the data phase, so both prompt and slow targets are seen
  always_ff @(posedge clk_sys) begin
    errPulse <= 5'h00;
    xferDone <= 1'b0;
    if (srst) begin
      busy <= 1'b0;
      cnt <= 3'h0;
    end else if (go) begin
      busy <= 1'b1;
      cnt <= {1'b0, lag} + 3'h2;
    end else if (busy) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h2) errPulse <= errSel;
      if (cnt == 3'h1) begin
        xferDone <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/result_if.sv ====
// Carrier between the reporter and its result queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface result_if import scsi_result_pkg::*; #(parameter int CW = 3);
  logic push0;
  logic push1;
  result_t d0;
  result_t d1;
  logic pop;
  result_t head;
  logic notEmpty;
  logic [CW-1:0] count;
  modport queue (input push0, push1, d0, d1, pop, output head, notEmpty, count);
  modport user (output push0, push1, d0, d1, pop, input head, notEmpty, count);
endinterface
`default_nettype wire

// ==== verilog/result_queue.sv ====
// Ordered holding queue of code/step results, up to two pushes a cycle.
// Pushes beyond free space are dropped by the queue itself; a pop in the same cycle frees no room.
`timescale 1ns/1ps
`default_nettype none
module result_queue import scsi_result_pkg::*; #(
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys,
  input wire logic srst,
  result_if.queue q
);
  typedef struct packed {
    result_t [DEPTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } qstate_t;
  qstate_t s_reg;
  qstate_t s_next;
  logic [CW-1:0] room;

  always_comb begin
    s_next = s_reg;
    room = CW'(DEPTH) - s_reg.cnt;
    // Full entries are read first so a pop never races a write
    if (q.pop && s_reg.cnt != '0) begin
      s_next.rd = AW'((32'(s_reg.rd) + 1) % DEPTH);
      s_next.cnt = s_next.cnt - 1'b1;
    end
    if (q.push0 && room != '0) begin
      s_next.mem[s_next.wr] = q.d0;
      s_next.wr = AW'((32'(s_next.wr) + 1) % DEPTH);
      s_next.cnt = s_next.cnt + 1'b1;
      room = room - 1'b1;
    end
    if (q.push1 && room != '0) begin
      s_next.mem[s_next.wr] = q.d1;
      s_next.wr = AW'((32'(s_next.wr) + 1) % DEPTH);
      s_next.cnt = s_next.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q.head = s_reg.mem[s_reg.rd];
  assign q.notEmpty = s_reg.cnt != '0;
  assign q.count = s_reg.cnt;
endmodule
`default_nettype wire

// ==== verilog/scsi_result_pkg.sv ====
// Result codes, register map and state types for the result reporter.
// Assumes a single 20 MHz clock domain and AXI4-Lite register access.
package scsi_result_pkg;
  localparam logic [7:0] C_RESET = 8'h01;
  localparam logic [7:0] C_DMAPAR = 8'h21;
  localparam logic [7:0] C_MPUPAR = 8'h22;
  localparam logic [7:0] C_SCSIPAR = 8'h24;
  localparam logic [7:0] C_DMASCSI = 8'h25;
  localparam logic [7:0] C_MPUSCSI = 8'h26;
  localparam logic [7:0] C_OFS = 8'h29;
  localparam logic [7:0] C_FAST = 8'h2a;
  localparam logic [7:0] C_OFSFAST = 8'h2b;
  localparam logic [7:0] C_BFXFER = 8'h31;
  localparam logic [7:0] C_PHASE = 8'h32;
  localparam logic [7:0] C_DONE = 8'h60;
  localparam logic [7:0] C_DOUBLE = 8'h64;
  localparam logic [7:0] C_PAUSE = 8'h67;
  localparam logic [7:0] C_BFIDLE = 8'h70;
  localparam logic [7:0] C_TMO = 8'h82;
  localparam logic [7:0] S00 = 8'h00;
  localparam logic [7:0] S01 = 8'h01;
  localparam logic [7:0] S02 = 8'h02;
  localparam logic [7:0] S03 = 8'h03;
  localparam logic [7:0] S09 = 8'h09;
  localparam logic [7:0] S0A = 8'h0a;
  localparam logic [3:0] ADDR_RESULT = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CTRL_AUTOACK = 0;
  localparam int CTRL_RETRY_LSB = 4;
  localparam int RETRY_W = 4;
  localparam int RESULT_VALID = 31;
  localparam logic [1:0] CMD_SEL = 2'b00;
  localparam logic [1:0] CMD_ATNACK = 2'b01;
  localparam logic [1:0] CMD_XFER = 2'b10;
  localparam logic [1:0] SP_WAITBF = 2'b00;
  localparam logic [1:0] SP_ARB = 2'b01;
  localparam logic [1:0] SP_SEL = 2'b10;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] step;
  } result_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEL = 3'b001,
    ST_RESEL = 3'b010,
    ST_ATNACK = 3'b011,
    ST_XFER = 3'b100,
    ST_EXIT = 3'b101
  } phase_t;
endpackage

// ==== verilog/scsi_result_reporter.sv ====
// Command result reporter: turns command progress events into code/step
// results, queues them, and serves them over AXI4-Lite.
// Assumes all event inputs are one-cycle pulses synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module scsi_result_reporter import scsi_result_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmdStart,
  input wire logic [1:0] cmdKind,
  input wire logic cmdSetAtn,
  input wire logic paddingOn,
  input wire logic [1:0] selPhase,
  input wire logic rstCond,
  input wire logic busFreeSeen,
  input wire logic prevWasXfer,
  input wire logic scsiRst,
  input wire logic arbLost,
  input wire logic reselected,
  input wire logic reselOpDone,
  input wire logic [7:0] reselCode,
  input wire logic [7:0] reselStep,
  input wire logic pauseAcc,
  input wire logic selDone,
  input wire logic selTimeout,
  input wire logic atnAckDone,
  input wire logic xferDone,
  input wire logic busFreeXfer,
  input wire logic phaseChange,
  input wire logic exitDone,
  input wire logic lastAckNeg,
  input wire logic dmaParErr,
  input wire logic mpuParErr,
  input wire logic scsiParErr,
  input wire logic offsetOvr,
  input wire logic reqTooFast,
  input wire logic regParErr,
  output logic atnReq,
  output logic retryReq,
  output logic resultPending
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    phase_t st;
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic autoAck;
    logic [RETRY_W-1:0] retryLimit;
    logic [RETRY_W-1:0] retryCnt;
    logic arbLostF;
    logic reselPendV;
    result_t reselPend;
    logic setAtnF;
    logic errDma;
    logic errMpu;
    logic errScsi;
    logic errOfs;
    logic errFast;
    logic regParF;
    result_t exitRes;
    logic atnReq;
    logic retryReq;
  } state_t;

  state_t s_reg;
  state_t s_next;
  result_if #(.CW(CW)) qIf ();

  result_queue #(.DEPTH(DEPTH)) queue_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .q(qIf.queue)
  );

  logic p0;
  logic p1;
  result_t d0;
  result_t d1;
  logic popNow;
  logic anyErr;
  logic step9;
  result_t errRes;

  assign anyErr = dmaParErr | mpuParErr | scsiParErr | offsetOvr | reqTooFast;

  always_comb begin
    s_next = s_reg;
    p0 = 1'b0;
    p1 = 1'b0;
    d0 = '0;
    d1 = '0;
    popNow = 1'b0;
    s_next.retryReq = 1'b0;
    // Step 09 only when the last acknowledge was released automatically
    step9 = s_reg.autoAck && lastAckNeg && !paddingOn;
    errRes.step = step9 ? S09 : S01;
    // Combined codes take priority over the single-side codes
    if (s_reg.errDma && s_reg.errScsi) begin
      errRes.code = C_DMASCSI;
    end else if (s_reg.errMpu && s_reg.errScsi) begin
      errRes.code = C_MPUSCSI;
    end else if (s_reg.errOfs && s_reg.errFast) begin
      errRes.code = C_OFSFAST;
    end else if (s_reg.errDma) begin
      errRes.code = C_DMAPAR;
    end else if (s_reg.errMpu) begin
      errRes.code = C_MPUPAR;
    end else if (s_reg.errScsi) begin
      errRes.code = C_SCSIPAR;
    end else if (s_reg.errOfs) begin
      errRes.code = C_OFS;
    end else begin
      errRes.code = C_FAST;
    end

    // Command sequencing
    case (s_reg.st)
      ST_IDLE: begin
        if (reselOpDone) begin
          s_next.reselPendV = 1'b1;
          s_next.reselPend = '{reselCode, reselStep};
        end
        if (cmdStart) begin
          s_next.setAtnF = cmdSetAtn;
          s_next.errDma = 1'b0;
          s_next.errMpu = 1'b0;
          s_next.errScsi = 1'b0;
          s_next.errOfs = 1'b0;
          s_next.errFast = 1'b0;
          case (cmdKind)
            CMD_SEL: begin
              if (s_reg.reselPendV) begin
                p0 = 1'b1;
                d0 = s_reg.reselPend;
                p1 = 1'b1;
                d1 = '{C_DOUBLE, S00};
                // Set wins: a result arriving now stays pending
                s_next.reselPendV = reselOpDone;
              end else begin
                s_next.st = ST_SEL;
                s_next.retryCnt = '0;
                s_next.arbLostF = 1'b0;
              end
            end
            CMD_ATNACK: begin
              if (rstCond) begin
                p0 = 1'b1;
                d0 = '{C_RESET, S00};
              end else if (busFreeSeen) begin
                p0 = 1'b1;
                if (prevWasXfer && !s_reg.autoAck) begin
                  d0 = '{C_BFXFER, S00};
                end else begin
                  d0 = '{C_BFIDLE, S00};
                end
              end else begin
                s_next.st = ST_ATNACK;
              end
            end
            CMD_XFER: begin
              if (rstCond) begin
                p0 = 1'b1;
                d0 = '{C_RESET, S00};
              end else if (busFreeSeen) begin
                p0 = 1'b1;
                d0 = '{C_BFIDLE, S00};
              end else begin
                s_next.st = ST_XFER;
              end
            end
            default: begin
              s_next.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_SEL: begin
        if (scsiRst) begin
          p0 = 1'b1;
          case (selPhase)
            SP_WAITBF: d0 = '{C_RESET, S00};
            SP_ARB: d0 = '{C_RESET, S01};
            default: d0 = '{C_RESET, S02};
          endcase
          s_next.st = ST_IDLE;
        end else if (pauseAcc && selPhase == SP_ARB) begin
          p0 = 1'b1;
          d0 = '{C_PAUSE, S01};
          s_next.st = ST_IDLE;
        end else if (reselected && s_reg.arbLostF) begin
          p0 = 1'b1;
          d0 = '{C_DOUBLE, S00};
          s_next.st = ST_RESEL;
        end else if (selTimeout) begin
          if (s_reg.retryCnt < s_reg.retryLimit) begin
            s_next.retryCnt = s_reg.retryCnt + 1'b1;
            s_next.retryReq = 1'b1;
          end else begin
            p0 = 1'b1;
            d0 = '{C_TMO, S02};
            s_next.st = ST_IDLE;
          end
        end else if (selDone) begin
          p0 = 1'b1;
          d0 = '{C_DONE, S03};
          s_next.st = ST_IDLE;
        end
        if (arbLost) begin
          s_next.arbLostF = 1'b1;
        end
      end
      ST_RESEL: begin
        if (reselOpDone) begin
          p0 = 1'b1;
          d0 = '{reselCode, reselStep};
          s_next.st = ST_IDLE;
        end
      end
      ST_ATNACK: begin
        if (atnAckDone) begin
          p0 = 1'b1;
          if (s_reg.setAtnF && step9) begin
            d0 = '{C_DONE, S09};
          end else begin
            d0 = '{C_DONE, S01};
          end
          s_next.st = ST_IDLE;
        end
      end
      ST_XFER: begin
        if (anyErr) begin
          s_next.atnReq = 1'b1;
        end
        s_next.errDma = s_reg.errDma | dmaParErr;
        s_next.errMpu = s_reg.errMpu | mpuParErr;
        s_next.errScsi = s_reg.errScsi | scsiParErr;
        s_next.errOfs = s_reg.errOfs | offsetOvr;
        s_next.errFast = s_reg.errFast | reqTooFast;
        // Exit-type events are held until exit processing ends
        if (scsiRst) begin
          s_next.exitRes = '{C_RESET, S01};
          s_next.st = ST_EXIT;
        end else if (pauseAcc) begin
          s_next.exitRes = '{C_PAUSE, S01};
          s_next.st = ST_EXIT;
        end else if (busFreeXfer) begin
          s_next.exitRes = '{C_BFXFER, S01};
          s_next.st = ST_EXIT;
        end else if (phaseChange) begin
          s_next.exitRes = '{C_PHASE, S01};
          s_next.st = ST_EXIT;
        end else if (xferDone) begin
          p0 = 1'b1;
          if (s_reg.errDma | s_reg.errMpu | s_reg.errScsi | s_reg.errOfs | s_reg.errFast) begin
            d0 = errRes;
          end else begin
            d0 = '{C_DONE, step9 ? S0A : S02};
          end
          s_next.atnReq = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      ST_EXIT: begin
        if (exitDone) begin
          p0 = 1'b1;
          d0 = s_reg.exitRes;
          s_next.atnReq = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Register parity seen anywhere trails the next result pushed alone in its cycle
    if (regParErr) begin
      s_next.regParF = 1'b1;
    end
    if (p0 && !p1 && (s_reg.regParF || regParErr)) begin
      p1 = 1'b1;
      d1 = '{C_MPUPAR, S00};
      s_next.regParF = 1'b0;
    end

    // AXI4-Lite write: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.awHeld = 1'b1;
      s_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.wHeld = 1'b1;
      s_next.wData = s_axi_wdata;
      s_next.wStrb = s_axi_wstrb;
    end
    if (s_reg.awHeld && s_reg.wHeld && !s_reg.bValid) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = RESP_OKAY;
      if (s_reg.awAddr == ADDR_CTRL) begin
        if (s_reg.wStrb[0]) begin
          s_next.autoAck = s_reg.wData[CTRL_AUTOACK];
          s_next.retryLimit = s_reg.wData[CTRL_RETRY_LSB +: RETRY_W];
        end
      end else if (s_reg.awAddr != ADDR_RESULT && s_reg.awAddr != ADDR_STATUS) begin
        s_next.bResp = RESP_SLVERR;
      end
    end
    if (s_reg.bValid && s_axi_bready) begin
      s_next.bValid = 1'b0;
    end

    // Read: fetching RESULT removes it, code and step in one word
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rValid = 1'b1;
      s_next.rResp = RESP_OKAY;
      s_next.rData = '0;
      case (s_axi_araddr)
        ADDR_RESULT: begin
          if (qIf.notEmpty) begin
            s_next.rData[15:0] = qIf.head;
            s_next.rData[RESULT_VALID] = 1'b1;
            popNow = 1'b1;
          end
        end
        ADDR_CTRL: begin
          s_next.rData[CTRL_AUTOACK] = s_reg.autoAck;
          s_next.rData[CTRL_RETRY_LSB +: RETRY_W] = s_reg.retryLimit;
        end
        ADDR_STATUS: begin
          s_next.rData[2:0] = s_reg.st;
          s_next.rData[3] = s_reg.atnReq;
          s_next.rData[7:4] = s_reg.retryCnt;
          s_next.rData[8 +: CW] = qIf.count;
        end
        default: begin
          s_next.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rValid && s_axi_rready) begin
      s_next.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign qIf.push0 = p0;
  assign qIf.push1 = p1;
  assign qIf.d0 = d0;
  assign qIf.d1 = d1;
  assign qIf.pop = popNow;

  assign s_axi_awready = !s_reg.awHeld;
  assign s_axi_wready = !s_reg.wHeld;
  assign s_axi_bvalid = s_reg.bValid;
  assign s_axi_bresp = s_reg.bResp;
  assign s_axi_arready = !s_reg.rValid;
  assign s_axi_rvalid = s_reg.rValid;
  assign s_axi_rdata = s_reg.rData;
  assign s_axi_rresp = s_reg.rResp;
  assign atnReq = s_reg.atnReq;
  assign retryReq = s_reg.retryReq;
  assign resultPending = qIf.notEmpty;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_sel_rst;
    s_reg.st == ST_SEL && scsiRst |-> p0 && d0.code == C_RESET
      && d0.step == {6'h00, selPhase == SP_SEL, selPhase == SP_ARB} ##1 s_reg.st == ST_IDLE;
  endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("select reset code wrong");

  property p_resel;
    s_reg.st == ST_SEL && !scsiRst && !pauseAcc && reselected && s_reg.arbLostF
      |-> d0 == result_t'{C_DOUBLE, S00} ##1 s_reg.st == ST_RESEL;
  endproperty
  a_resel: assert property (p_resel) else $error("reselection not reported first");

  property p_resel_late;
    s_reg.st == ST_IDLE && cmdStart && cmdKind == CMD_SEL && s_reg.reselPendV
      |-> p0 && p1 && d0 == s_reg.reselPend && d1.code == C_DOUBLE;
  endproperty
  a_resel_late: assert property (p_resel_late) else $error("late reselection order wrong");

  property p_pause;
    s_reg.st == ST_SEL && !scsiRst && pauseAcc && selPhase == SP_ARB
      |-> d0 == result_t'{C_PAUSE, S01};
  endproperty
  a_pause: assert property (p_pause) else $error("pause code wrong");

  property p_retry;
    p0 && d0.code == C_TMO |-> s_reg.retryCnt == s_reg.retryLimit && d0.step == S02;
  endproperty
  a_retry: assert property (p_retry) else $error("timeout before retries done");

  property p_bf;
    s_reg.st == ST_IDLE && cmdStart && cmdKind == CMD_ATNACK && !rstCond && busFreeSeen
      |-> d0.code == ((prevWasXfer && !s_reg.autoAck) ? C_BFXFER : C_BFIDLE);
  endproperty
  a_bf: assert property (p_bf) else $error("bus free code wrong");

  property p_step9;
    p0 && d0.step == S09 |-> s_reg.autoAck && !paddingOn && lastAckNeg;
  endproperty
  a_step9: assert property (p_step9) else $error("step 09 outside automatic mode");

  property p_atn;
    s_reg.st == ST_XFER && anyErr |=> atnReq [*1] ##0 s_reg.errDma == $past(dmaParErr | s_reg.errDma);
  endproperty
  a_atn: assert property (p_atn) else $error("ATN not raised on error");

  property p_exit;
    s_reg.st == ST_EXIT && !exitDone |-> !p0;
  endproperty
  a_exit: assert property (p_exit) else $error("report before exit processing");

  property p_regpar;
    p0 && !(s_reg.st == ST_IDLE && s_reg.reselPendV && cmdStart) && s_reg.regParF
      |-> p1 && d1 == result_t'{C_MPUPAR, S00};
  endproperty
  a_regpar: assert property (p_regpar) else $error("trailing 22/00 missing");

  property p_pend;
    p0 && qIf.count == '0 && !popNow |=> resultPending;
  endproperty
  a_pend: assert property (p_pend) else $error("result not held");

  c_resel: cover property (s_reg.st == ST_RESEL ##[1:20] p0);
  c_exit: cover property (s_reg.st == ST_EXIT ##[1:20] exitDone);
  c_err: cover property (p0 && d0.code == C_DMASCSI);
  c_tmo: cover property (retryReq ##[1:50] p0 && d0.code == C_TMO);
endmodule
`default_nettype wire
